// ---- design/omc_mem_ctrl.v ----
// Purpose: On-card memory controller: boot ROM decode, DRAM sequencer, store port.
// Assumes: Processor issues one cycle at a time with req held until ack.
// Notes: ROM chip and DRAM array are outside; this block drives their strobes.
`default_nettype none
`include "omc_defs.vh"

// Overview of operation
// - After reset every address reads boot ROM
// - First ROM-window access enables normal map
// - ROM is 1 Mbyte byte-wide region
// - Writes pass to ROM socket for paging
// - DRAM decoded from zero, 2 or 8 Mbytes
// - Optional per-byte parity generated and checked
// - Read 4 clocks, write 2 clocks
// - Burst read 7 clocks, waits 2-0-0-0
// - Posted writes; burst write 5 clocks
// - Hidden refresh, delays access only if pending
// - Back-to-back DRAM cycles get two extra waits
// - Store bytes spaced eight addresses apart
// - Store at base, writes need unlock
// - Test-and-set at unlock address arms write
// - Busy write reads complemented data for 10 ms
// - Upper quarter writable only with jumper
// - Parity mismatch raises level-7 request
module omc_mem_ctrl #(
  parameter BIG_RAM = 1'b0,
  parameter PARITY_EN = 1'b1,
  parameter NV_WR_CYC = `OMC_NV_WR_CYC,
  parameter RFSH_CYC = `OMC_RFSH_NS / `OMC_CLK_NS
) (
  input wire core_clk,
  input wire rst,
  input wire req,
  input wire wr,
  input wire rmw,
  input wire burst,
  input wire [31:0] addr,
  input wire [31:0] wdata,
  output reg [31:0] rdata_q,
  output wire ack,
  output reg last_q,
  output wire rom_cs,
  output wire rom_we,
  output wire [19:0] rom_addr,
  input wire [7:0] rom_rdata,
  output reg dram_cyc_q,
  output reg dram_we_q,
  output reg dram_rfsh_q,
  output reg dram_bank_q,
  output reg [22:0] dram_addr_q,
  output reg [31:0] dram_wdata_q,
  output reg [3:0] dram_wpar_q,
  input wire [31:0] dram_rdata,
  input wire [3:0] dram_rpar,
  input wire protect_jmp_raw,
  output reg irq7_q
);

  localparam S_IDLE = 3'd0;
  localparam S_WAIT = 3'd1;
  localparam S_BEAT = 3'd2;
  localparam S_RFSH = 3'd3;
  localparam S_GAP = 3'd4;
  localparam S_DONE = 3'd5;
  // Counter loads; the gap's detecting edge and its exit edge are its two clocks
  localparam RFSH_LEN = `OMC_RFSH_CLKS - 1;
  localparam GAP_LEN = `OMC_B2B_WAIT - 2;
  localparam RD_LEN = `OMC_RD_CLKS - 2;

  reg [2:0] st_q;
  reg normal_q;
  reg [3:0] cnt_q;
  reg [1:0] beat_q;
  reg b2b_q;
  reg [15:0] rtmr_q;
  reg rpend_q;
  reg prot_s1_q;
  reg prot_s2_q;
  reg nv_ack_q;
  reg rom_ack_q;
  reg dram_ack;
  wire in_rom;
  wire in_ram;
  wire in_nv;
  wire is_unlock;
  wire nv_acc;
  wire [7:0] nv_rdata;
  wire [31:0] ram_top;
  reg [3:0] par_err;

  function [3:0] parity4;
    input [31:0] d;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        parity4[k] = ^d[8*k +: 8];
      end
    end
  endfunction

  // ==========================================================================
  // Decode
  assign ram_top = BIG_RAM ? `OMC_RAM_8M : `OMC_RAM_2M;
  assign in_rom = !normal_q || ((addr >= `OMC_ROM_LO) && (addr < `OMC_ROM_HI));
  assign in_ram = normal_q && (addr < ram_top);
  assign in_nv = normal_q && (addr >= `OMC_NV_BASE) && (addr < `OMC_NV_END);
  assign is_unlock = normal_q && rmw && (addr == `OMC_NV_UNLOCK);
  assign nv_acc = req && in_nv && !nv_ack_q;

  always @(posedge core_clk) begin
    if (rst) begin
      normal_q <= 1'b0;
    end else if (req && (addr >= `OMC_ROM_LO) && (addr < `OMC_ROM_HI)) begin
      normal_q <= 1'b1;
    end
  end

  // ==========================================================================
  // ROM socket: byte wide, writes reach the part (paging or erasable parts)
  assign rom_cs = req && in_rom;
  assign rom_we = req && in_rom && wr;
  assign rom_addr = addr[19:0];

  always @(posedge core_clk) begin
    if (rst) begin
      rom_ack_q <= 1'b0;
    end else begin
      rom_ack_q <= req && in_rom && !rom_ack_q;
    end
  end

  // ==========================================================================
  // Protect jumper synchroniser
  always @(posedge core_clk) begin
    if (rst) begin
      prot_s1_q <= 1'b0;
      prot_s2_q <= 1'b0;
    end else begin
      prot_s1_q <= protect_jmp_raw;
      prot_s2_q <= prot_s1_q;
    end
  end

  // ==========================================================================
  // Nonvolatile store; any other non-RAM peripheral access consumes unlock
  always @(posedge core_clk) begin
    if (rst) begin
      nv_ack_q <= 1'b0;
    end else begin
      nv_ack_q <= req && (in_nv || is_unlock) && !nv_ack_q;
    end
  end

  omc_nv_store #(
    .AW(13),
    .WR_CYC(NV_WR_CYC)
  ) u_nv (
    .core_clk(core_clk),
    .rst(rst),
    .acc(nv_acc || (req && normal_q && !in_ram && !in_nv && !is_unlock && !rom_ack_q && !nv_ack_q)),
    .wr(wr && in_nv),
    .unlock(req && is_unlock && !nv_ack_q),
    .protect_ok(prot_s2_q),
    .idx(addr[15:3]),
    .wdata(wdata[7:0]),
    .rdata_q(nv_rdata),
    .busy()
  );

  // ==========================================================================
  // Refresh timer
  always @(posedge core_clk) begin
    if (rst) begin
      rtmr_q <= 16'h0;
      rpend_q <= 1'b0;
    end else begin
      if (st_q == S_RFSH && cnt_q == 4'd0) begin
        rpend_q <= 1'b0;
      end
      // A period ending as a refresh finishes must stay pending, so set wins
      if (rtmr_q == RFSH_CYC[15:0] - 16'h1) begin
        rtmr_q <= 16'h0;
        rpend_q <= 1'b1;
      end else begin
        rtmr_q <= rtmr_q + 16'h1;
      end
    end
  end

  // ==========================================================================
  // DRAM sequencer
  always @(posedge core_clk) begin
    if (rst) begin
      st_q <= S_IDLE;
      cnt_q <= 4'd0;
      beat_q <= 2'd0;
      b2b_q <= 1'b0;
      dram_cyc_q <= 1'b0;
      dram_we_q <= 1'b0;
      dram_rfsh_q <= 1'b0;
      dram_bank_q <= 1'b0;
      dram_addr_q <= 23'h0;
      dram_wdata_q <= 32'h0;
      dram_wpar_q <= 4'h0;
      last_q <= 1'b0;
    end else begin
      last_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          dram_cyc_q <= 1'b0;
          dram_rfsh_q <= 1'b0;
          if (rpend_q && !(req && in_ram)) begin
            st_q <= S_RFSH;
            cnt_q <= RFSH_LEN[3:0];
            dram_rfsh_q <= 1'b1;
          end else if (req && in_ram && rpend_q) begin
            st_q <= S_RFSH;
            cnt_q <= RFSH_LEN[3:0];
            dram_rfsh_q <= 1'b1;
          end else if (req && in_ram && b2b_q) begin
            st_q <= S_GAP;
            cnt_q <= GAP_LEN[3:0];
          end else if (req && in_ram) begin
            dram_cyc_q <= 1'b1;
            dram_we_q <= wr;
            dram_addr_q <= addr[22:0];
            dram_bank_q <= addr[2];
            dram_wdata_q <= wdata;
            dram_wpar_q <= PARITY_EN ? parity4(wdata) : 4'h0;
            beat_q <= 2'd0;
            st_q <= wr ? S_BEAT : S_WAIT;
            cnt_q <= wr ? 4'd0 : RD_LEN[3:0];
          end
          b2b_q <= 1'b0;
        end
        S_RFSH: begin
          if (cnt_q == 4'd0) begin
            st_q <= S_IDLE;
            dram_rfsh_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 4'd1;
          end
        end
        S_GAP: begin
          if (cnt_q == 4'd0) begin
            st_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'd1;
          end
        end
        S_WAIT: begin
          if (cnt_q == 4'd1) begin
            st_q <= S_BEAT;
          end
          cnt_q <= cnt_q - 4'd1;
        end
        S_BEAT: begin
          dram_we_q <= wr;
          dram_wdata_q <= wdata;
          dram_wpar_q <= PARITY_EN ? parity4(wdata) : 4'h0;
          // Posted data is taken at the edge acknowledging its beat, so a write
          // steps its address one beat later than a read does
          if (dram_we_q ? (beat_q != 2'd0) : (burst && (beat_q != 2'd3))) begin
            dram_bank_q <= ~dram_bank_q;
            dram_addr_q <= dram_addr_q + 23'd4;
          end
          if (!burst || beat_q == 2'd3) begin
            st_q <= S_DONE;
            last_q <= 1'b1;
          end else begin
            beat_q <= beat_q + 2'd1;
          end
        end
        S_DONE: begin
          dram_cyc_q <= 1'b0;
          st_q <= S_IDLE;
          // A request at the first idle edge is back to back
          b2b_q <= 1'b1;
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  always @* begin
    dram_ack = (st_q == S_BEAT);
  end

  // ==========================================================================
  // Read data, parity check
  always @* begin
    par_err = parity4(dram_rdata) ^ dram_rpar;
  end

  always @(posedge core_clk) begin
    if (rst) begin
      irq7_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      if (dram_ack && !dram_we_q && PARITY_EN && (par_err != 4'h0)) begin
        irq7_q <= 1'b1;
      end
      if (dram_ack) begin
        rdata_q <= dram_rdata;
      end else if (rom_cs) begin
        rdata_q <= {4{rom_rdata}};
      end else if (nv_ack_q && !wr) begin
        // Store byte was fetched at the take edge; hand it over with the ack
        rdata_q <= {4{nv_rdata}};
      end
    end
  end

  assign ack = dram_ack || rom_ack_q || (nv_ack_q && !in_ram && !in_rom);

endmodule // omc_mem_ctrl
`default_nettype wire

// ---- design/omc_defs.vh ----
// Purpose: Constants for the on-card memory controller.
// Assumes: Processor local bus with byte addresses, 100 MHz core clock.
// Notes: Address windows, cycle counts and timing figures live here.
`ifndef OMC_DEFS_VH
`define OMC_DEFS_VH

// ==========================================================================
// Address map
`define OMC_ROM_LO 32'hFC000000
`define OMC_ROM_HI 32'hFC400000
`define OMC_ROM_MASK 32'h000FFFFF
`define OMC_RAM_BASE 32'h00000000
`define OMC_RAM_2M 32'h00200000
`define OMC_RAM_8M 32'h00800000
`define OMC_NV_BASE 32'hFF020000
`define OMC_NV_END 32'hFF030000
`define OMC_NV_PROT 32'hFF02C000
`define OMC_NV_UNLOCK 32'hFF010C00
`define OMC_NV_STRIDE_SH 3
`define OMC_ROM_PAGE_BYTES 16384

// ==========================================================================
// DRAM timing in clocks; refresh period and clock period in ns
`define OMC_RD_CLKS 4
`define OMC_WR_CLKS 2
`define OMC_BRD_CLKS 7
`define OMC_BWR_CLKS 5
`define OMC_B2B_WAIT 2
`define OMC_RFSH_CLKS 3
`define OMC_RFSH_NS 15600
`define OMC_CLK_NS 10

// ==========================================================================
// Nonvolatile store write time
`define OMC_NV_WR_MS 10
`define OMC_NV_WR_CYC ((`OMC_NV_WR_MS * 1000000) / `OMC_CLK_NS)

`endif

// ---- design/omc_nv_store.v ----
// Purpose: Byte-wide nonvolatile store with one-shot unlock and write timer.
// Assumes: Caller decodes the store window and qualifies accesses.
// Notes: Only one write can be in flight; the busy address reads inverted.
`default_nettype none
`include "omc_defs.vh"

module omc_nv_store #(
  parameter AW = 13,
  parameter WR_CYC = `OMC_NV_WR_CYC
) (
  input wire core_clk,
  input wire rst,
  input wire acc,
  input wire wr,
  input wire unlock,
  input wire protect_ok,
  input wire [AW-1:0] idx,
  input wire [7:0] wdata,
  output reg [7:0] rdata_q,
  output wire busy
);

  reg [7:0] mem [0:(1<<AW)-1];
  reg armed_q;
  reg [31:0] tmr_q;
  reg [AW-1:0] bidx_q;
  reg [7:0] bdat_q;
  wire prot_hit;
  wire do_wr;

  // ==========================================================================
  // Write acceptance
  assign prot_hit = (idx[AW-1:AW-2] == 2'b11) && !protect_ok;
  assign do_wr = acc && wr && armed_q && !prot_hit && (tmr_q == 32'h0);
  assign busy = (tmr_q != 32'h0);

  always @(posedge core_clk) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (unlock) begin
      armed_q <= 1'b1;
    end else if (acc) begin
      armed_q <= 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      tmr_q <= 32'h0;
      bidx_q <= {AW{1'b0}};
      bdat_q <= 8'h00;
    end else if (do_wr) begin
      tmr_q <= WR_CYC;
      bidx_q <= idx;
      bdat_q <= wdata;
    end else if (tmr_q != 32'h0) begin
      tmr_q <= tmr_q - 32'h1;
    end
  end

  // Array updated at write start; the timer governs what reads see and holds off further writes
  always @(posedge core_clk) begin
    if (do_wr) begin
      mem[idx] <= wdata;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (acc && !wr) begin
      if (busy && (idx == bidx_q)) begin
        rdata_q <= ~bdat_q;
      end else begin
        rdata_q <= mem[idx];
      end
    end
  end

endmodule // omc_nv_store
`default_nettype wire

// ---- sim/omc_mem_model.sv ----
// Purpose: Far-side model of the boot ROM chip and the DRAM array.
// Assumes: DRAM strobes are registered, ROM select is not; reads see the array directly.
// Notes: Parity is even per byte; corrupt flips it to force an error.
`default_nettype none
module omc_mem_model (
  input wire logic core_clk,
  input wire logic rom_cs,
  input wire logic [19:0] rom_addr,
  output logic [7:0] rom_rdata,
  input wire logic dram_cyc_q,
  input wire logic dram_we_q,
  input wire logic [22:0] dram_addr_q,
  input wire logic [31:0] dram_wdata_q,
  input wire logic corrupt,
  output logic [31:0] dram_rdata,
  output logic [3:0] dram_rpar
);
  timeunit 1ns;
  timeprecision 1ns;
  bit [31:0] mem [0:255];
  logic [31:0] v;
  logic [7:0] rb;
  // ==========================================================================
  // Storage
  // A deselected ROM shows inverted data, so a late sample cannot match
  assign rb = rom_addr[7:0] ^ 8'h5A;
  assign rom_rdata = rom_cs ? rb : ~rb;
  assign v = mem[dram_addr_q[7:0]];
  assign dram_rdata = v;
  assign dram_rpar = {^v[31:24], ^v[23:16], ^v[15:8], ^v[7:0]} ^ {4{corrupt}};
  always @(posedge core_clk) begin
    if (dram_cyc_q && dram_we_q) begin
      mem[dram_addr_q[7:0]] <= dram_wdata_q;
    end
  end
endmodule // omc_mem_model
`default_nettype wire

// ---- sim/omc_mem_ctrl_sva.sv ----
// Purpose: Temporal checks on the memory controller ports.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Parity is taken as even per byte.
`default_nettype none
module omc_mem_ctrl_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req,
  input wire logic wr,
  input wire logic [31:0] addr,
  input wire logic ack,
  input wire logic last_q,
  input wire logic rom_cs,
  input wire logic rom_we,
  input wire logic [19:0] rom_addr,
  input wire logic dram_cyc_q,
  input wire logic dram_we_q,
  input wire logic dram_rfsh_q,
  input wire logic dram_bank_q,
  input wire logic [22:0] dram_addr_q,
  input wire logic [31:0] dram_wdata_q,
  input wire logic [3:0] dram_wpar_q,
  input wire logic irq7_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Properties
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_rd_wait;
    !ack ##1 ack;
  endsequence
  sequence s_rfsh;
    dram_rfsh_q [*3] ##1 !dram_rfsh_q;
  endsequence
  property p_rd_ack;
    $rose(dram_cyc_q) && !dram_we_q && !dram_rfsh_q |=> s_rd_wait;
  endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read ack timing");
  property p_no_ack;
    !req |-> !ack;
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("ack without request");
  property p_last;
    last_q |-> $past(ack);
  endproperty
  a_last: assert property (p_last) else $error("last without ack");
  property p_rfsh;
    $rose(dram_rfsh_q) |-> s_rfsh;
  endproperty
  a_rfsh: assert property (p_rfsh) else $error("refresh length");
  property p_rom_addr;
    rom_cs |-> rom_addr == addr[19:0];
  endproperty
  a_rom_addr: assert property (p_rom_addr) else $error("rom address");
  property p_rom_we;
    rom_we |-> rom_cs && wr && req;
  endproperty
  a_rom_we: assert property (p_rom_we) else $error("rom write strobe");
  property p_rom_ack;
    req && rom_cs && !ack |=> ack;
  endproperty
  a_rom_ack: assert property (p_rom_ack) else $error("rom ack timing");
  property p_par;
    dram_cyc_q && dram_we_q |-> dram_wpar_q == {^dram_wdata_q[31:24], ^dram_wdata_q[23:16],
      ^dram_wdata_q[15:8], ^dram_wdata_q[7:0]};
  endproperty
  a_par: assert property (p_par) else $error("write parity");
  property p_ram_lo;
    dram_cyc_q && !dram_rfsh_q |-> dram_addr_q < 23'h200000;
  endproperty
  a_ram_lo: assert property (p_ram_lo) else $error("dram address range");
  property p_irq;
    irq7_q |=> irq7_q;
  endproperty
  a_irq: assert property (p_irq) else $error("parity request dropped");
  property p_bank;
    dram_cyc_q && !dram_rfsh_q |-> dram_bank_q == dram_addr_q[2];
  endproperty
  a_bank: assert property (p_bank) else $error("bank select");
endmodule // omc_mem_ctrl_sva
bind omc_mem_ctrl omc_mem_ctrl_sva omc_mem_ctrl_sva_inst (.core_clk(core_clk), .rst(rst), .req(req),
  .wr(wr), .addr(addr), .ack(ack), .last_q(last_q), .rom_cs(rom_cs), .rom_we(rom_we),
  .rom_addr(rom_addr), .dram_cyc_q(dram_cyc_q), .dram_we_q(dram_we_q), .dram_rfsh_q(dram_rfsh_q),
  .dram_bank_q(dram_bank_q),
  .dram_addr_q(dram_addr_q), .dram_wdata_q(dram_wdata_q), .dram_wpar_q(dram_wpar_q), .irq7_q(irq7_q));
`default_nettype wire

// ---- sim/omc_mem_ctrl_tb_top.sv ----
// Purpose: Self-checking bench for the on-card memory controller.
// Assumes: The bench plays the processor and drives at the falling edge.
// Notes: Short store write time keeps the run brief; refresh period is set to 2000 clocks.
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module omc_mem_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic w; logic b; logic [31:0] a; logic [31:0] d; logic [31:0] e; int c;} omc_row_t;
  logic core_clk, rst, req, wr, rmw, burst, corrupt, protect_jmp_raw;
  logic ack, last_q, rom_cs, rom_we, dram_cyc_q, dram_we_q, dram_rfsh_q, dram_bank_q, irq7_q;
  logic [31:0] addr, wdata, rdata_q, dram_rdata, dram_wdata_q;
  logic [31:0] got [0:3];
  logic [19:0] rom_addr;
  logic [7:0] rom_rdata;
  logic [22:0] dram_addr_q;
  logic [3:0] dram_wpar_q, dram_rpar;
  int miscompares, cmp_count, clks, i, k;
  omc_row_t rows [0:4];
  omc_mem_ctrl #(.NV_WR_CYC(50), .RFSH_CYC(2000)) omc_mem_ctrl_inst (.core_clk(core_clk), .rst(rst),
    .req(req), .wr(wr), .rmw(rmw), .burst(burst), .addr(addr), .wdata(wdata), .rdata_q(rdata_q),
    .ack(ack), .last_q(last_q), .rom_cs(rom_cs), .rom_we(rom_we), .rom_addr(rom_addr),
    .rom_rdata(rom_rdata), .dram_cyc_q(dram_cyc_q), .dram_we_q(dram_we_q), .dram_rfsh_q(dram_rfsh_q),
    .dram_bank_q(dram_bank_q), .dram_addr_q(dram_addr_q), .dram_wdata_q(dram_wdata_q),
    .dram_wpar_q(dram_wpar_q), .dram_rdata(dram_rdata), .dram_rpar(dram_rpar),
    .protect_jmp_raw(protect_jmp_raw), .irq7_q(irq7_q));
  omc_mem_model omc_mem_model_inst (.core_clk(core_clk), .rom_cs(rom_cs), .rom_addr(rom_addr),
    .rom_rdata(rom_rdata), .dram_cyc_q(dram_cyc_q), .dram_we_q(dram_we_q), .dram_addr_q(dram_addr_q),
    .dram_wdata_q(dram_wdata_q), .corrupt(corrupt), .dram_rdata(dram_rdata), .dram_rpar(dram_rpar));
  // ==========================================================================
  // Processor cycles
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Called at a falling edge; clks counts edges from take to the final ack
  task automatic bus(input logic w, input logic b, input logic m, input logic [31:0] a, input logic [31:0] d);
    int n, c, nb;
    bit p;
    n = 0;
    c = 0;
    p = 0;
    nb = b ? 4 : 1;
    wr = w;
    burst = b;
    rmw = m;
    addr = a;
    wdata = d;
    req = 1'h1;
    while (c < nb && n < 40) begin
      @(negedge core_clk);
      n++;
      if (p) begin
        got[c-1] = rdata_q;
        wdata = d + c;
      end
      p = (ack === 1'h1);
      if (p) c++;
    end
    @(negedge core_clk);
    if (p) got[c-1] = rdata_q;
    req = 1'h0;
    rmw = 1'h0;
    clks = n + 1;
    if (c < nb) miscompares++;
  endtask
  task automatic rd8(input logic [31:0] a, input logic [7:0] e);
    bus(1'h0, 1'h0, 1'h0, a, 32'h0);
    idle(1);
    `CHK(got[0][7:0], e)
  endtask
  // The unlock is one-shot, so the store write must follow it directly
  task automatic nv(input logic [31:0] a, input logic [7:0] d, input logic u);
    if (u) begin
      bus(1'h0, 1'h0, 1'h1, 32'hFF010C00, 32'h0);
      idle(1);
    end
    bus(1'h1, 1'h0, 1'h0, a, {24'h0, d});
    idle(1);
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Whole run is about 2500 cycles; eight times that means a hang
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
  // ==========================================================================
  // Tests
  initial begin
    rows[0] = '{1'h1, 1'h0, 32'h40, 32'h12345678, 32'h0, 2};
    rows[1] = '{1'h0, 1'h0, 32'h40, 32'h0, 32'h12345678, 4};
    rows[2] = '{1'h1, 1'h1, 32'h80, 32'hA0000000, 32'h0, 5};
    rows[3] = '{1'h0, 1'h1, 32'h80, 32'h0, 32'hA0000000, 7};
    rows[4] = '{1'h0, 1'h0, 32'hFC000021, 32'h0, 32'h7B7B7B7B, 0};
    rst = 1'h1;
    {req, wr, rmw, burst, corrupt, addr, wdata} = '0;
    protect_jmp_raw = 1'h1;
    idle(20);
    rst = 1'h0;
    idle(1);
    bus(1'h0, 1'h0, 1'h0, 32'h13, 32'h0);
    `CHK(got[0], 32'h49494949)
    idle(3);
    bus(1'h0, 1'h0, 1'h0, 32'hFC000000, 32'h0);
    `CHK(got[0], 32'h5A5A5A5A)
    idle(3);
    bus(1'h1, 1'h0, 1'h0, 32'hFC000000, 32'h3);
    idle(3);
    $display("test boot done");
    for (i = 0; i < 5; i++) begin
      bus(rows[i].w, rows[i].b, 1'h0, rows[i].a, rows[i].d);
      if (rows[i].c != 0) `CHK(clks, rows[i].c)
      for (k = 0; k < (rows[i].b ? 4 : 1); k++) if (!rows[i].w) `CHK(got[k], rows[i].e + k)
      idle(3);
    end
    $display("test table done");
    bus(1'h0, 1'h0, 1'h0, 32'h40, 32'h0);
    idle(1);
    bus(1'h0, 1'h0, 1'h0, 32'h40, 32'h0);
    `CHK(clks, 6)
    idle(3);
    $display("test back to back done");
    nv(32'hFF020008, 8'h3C, 1'h1);
    rd8(32'hFF020008, 8'hC3);
    idle(60);
    rd8(32'hFF020008, 8'h3C);
    nv(32'hFF020008, 8'h77, 1'h0);
    idle(60);
    rd8(32'hFF020008, 8'h3C);
    nv(32'hFF02C000, 8'h55, 1'h1);
    idle(60);
    protect_jmp_raw = 1'h0;
    idle(3);
    nv(32'hFF02C000, 8'hAA, 1'h1);
    idle(60);
    rd8(32'hFF02C000, 8'h55);
    bus(1'h0, 1'h0, 1'h1, 32'hFF010C00, 32'h0);
    idle(1);
    bus(1'h0, 1'h0, 1'h0, 32'hFF020010, 32'h0);
    idle(1);
    nv(32'hFF020008, 8'h99, 1'h0);
    idle(60);
    rd8(32'hFF020008, 8'h3C);
    $display("test store done");
    idle(2100);
    `CHK(irq7_q, 1'h0)
    corrupt = 1'h1;
    bus(1'h0, 1'h0, 1'h0, 32'h40, 32'h0);
    corrupt = 1'h0;
    idle(3);
    `CHK(irq7_q, 1'h1)
    $display("test parity done");
    complete_run();
  end
endmodule // omc_mem_ctrl_tb_top
`default_nettype wire
